// *** design/black_clamp_and_output_format.sv ***
// Black clamp loop, pixel FIFO and output latch/format stage
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module pixel_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW:0] count;
    } fifo_s;

    fifo_s st_r;
    fifo_s st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (st_r.count != DEPTH[PW:0]);
    assign out_valid = (st_r.count != '0);
    assign out_data = mem[st_r.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wptr = (st_r.wptr == PW'(DEPTH - 1)) ? '0 : st_r.wptr + 1'b1;
        end
        if (pop) begin
            st_nxt.rptr = (st_r.rptr == PW'(DEPTH - 1)) ? '0 : st_r.rptr + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.count = st_r.count + 1'b1;
        end else if (pop && !push) begin
            st_nxt.count = st_r.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[st_r.wptr] <= in_data;
        end
    end
endmodule : pixel_fifo

module black_clamp_and_output_format #(
    parameter int PIX_DIV = 4,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire clamp_fmt_pkg::bus_req_s bus_req,
    output logic [clamp_fmt_pkg::BUS_W-1:0] rdata,
    input wire logic [clamp_fmt_pkg::ADC_W-1:0] adc_data,
    input wire logic adc_valid,
    output logic adc_ready,
    input wire logic black_clamp_pulse,
    input wire logic pixel_blank_pulse,
    output logic [clamp_fmt_pkg::CORR_W-1:0] dac_code,
    output logic [clamp_fmt_pkg::ADC_W-1:0] data_out,
    output logic [clamp_fmt_pkg::ADC_W-1:0] data_oe,
    output logic data_valid
);
    import clamp_fmt_pkg::*;

    typedef struct packed {
        regs_s regs;
        logic [PHASE_W-1:0] phase_cnt;
        clamp_st_e clamp_st;
        logic signed [ACC_W-1:0] acc;
        logic signed [ADC_W:0] err;
        logic [7:0] line_cnt;
        logic [CORR_W-1:0] corr;
        logic [ADC_W-1:0] dout;
        logic dvalid;
        logic [BUS_W-1:0] rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic [ADC_W-1:0] fifo_dout;
    logic fifo_valid;
    logic fifo_pop;
    logic sample;
    logic loop_off;
    logic transparent;
    logic latch_tick;
    logic upd_evt;
    logic signed [ACC_W-1:0] step;
    logic signed [ACC_W-1:0] corr_sum;

    function automatic logic [ADC_W-1:0] bin2gray(input logic [ADC_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [7:0] lines_per_update(input logic [7:0] n);
        return (n == 8'h00) ? 8'h01 : n;
    endfunction : lines_per_update

    pixel_fifo #(
        .WIDTH(ADC_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_data(adc_data),
        .in_valid(adc_valid),
        .in_ready(adc_ready),
        .out_data(fifo_dout),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    assign sample = adc_valid && adc_ready;
    assign loop_off = st_r.regs.opmode[OPMODE_CLAMP_OFF_BIT];
    assign transparent = st_r.regs.ctrl[CTRL_TRANSP_BIT];
    assign latch_tick = (st_r.phase_cnt == st_r.regs.phase);
    // Latch waits for its phase, so a slow phase stalls the FIFO and the source
    assign fifo_pop = fifo_valid && (transparent || latch_tick);
    // Clamp interval closes on the falling edge of the pulse
    assign upd_evt = !loop_off && st_r.clamp_st == CL_ACCUM && !black_clamp_pulse
        && (st_r.line_cnt + 8'h01 >= lines_per_update(st_r.regs.update));
    assign step = st_r.acc >>> FILT_SHIFT;
    assign corr_sum = ACC_W'($signed({1'b0, st_r.corr})) + step;

    always_comb begin
        st_nxt = st_r;
        st_nxt.dvalid = 1'b0;
        st_nxt.rdata = '0;
        st_nxt.phase_cnt = (st_r.phase_cnt == PHASE_W'(PIX_DIV - 1)) ? '0
            : st_r.phase_cnt + 1'b1;

        if (bus_req.wr) begin
            if (bus_req.addr == ADDR_OPMODE) begin
                st_nxt.regs.opmode = bus_req.wdata[7:0];
            end else if (bus_req.addr == ADDR_CTRL) begin
                st_nxt.regs.ctrl = bus_req.wdata[7:0];
            end else if (bus_req.addr == ADDR_LEVEL) begin
                st_nxt.regs.level = bus_req.wdata[LEVEL_W-1:0];
            end else if (bus_req.addr == ADDR_PHASE) begin
                st_nxt.regs.phase = bus_req.wdata[PHASE_W-1:0];
            end else if (bus_req.addr == ADDR_UPDATE) begin
                st_nxt.regs.update = bus_req.wdata[7:0];
            end
        end
        if (bus_req.rd) begin
            if (bus_req.addr == ADDR_OPMODE) begin
                st_nxt.rdata = BUS_W'(st_r.regs.opmode);
            end else if (bus_req.addr == ADDR_CTRL) begin
                st_nxt.rdata = BUS_W'(st_r.regs.ctrl);
            end else if (bus_req.addr == ADDR_LEVEL) begin
                st_nxt.rdata = BUS_W'(st_r.regs.level);
            end else if (bus_req.addr == ADDR_PHASE) begin
                st_nxt.rdata = BUS_W'(st_r.regs.phase);
            end else if (bus_req.addr == ADDR_UPDATE) begin
                st_nxt.rdata = BUS_W'(st_r.regs.update);
            end else if (bus_req.addr == ADDR_CORR) begin
                st_nxt.rdata = BUS_W'(st_r.corr);
            end else if (bus_req.addr == ADDR_STATUS) begin
                st_nxt.rdata = {st_r.err[ADC_W:0], pixel_blank_pulse,
                    st_r.clamp_st, fifo_valid};
            end
        end

        if (loop_off) begin
            // Loop frozen; the target acts as a fixed offset instead
            st_nxt.clamp_st = CL_IDLE;
            st_nxt.acc = '0;
            st_nxt.line_cnt = '0;
            st_nxt.corr = CORR_W'(st_r.regs.level);
        end else begin
            case (st_r.clamp_st)
                CL_IDLE: begin
                    if (black_clamp_pulse) begin
                        st_nxt.clamp_st = CL_ACCUM;
                    end
                end
                CL_ACCUM: begin
                    if (!black_clamp_pulse) begin
                        st_nxt.clamp_st = CL_IDLE;
                        if (upd_evt) begin
                            st_nxt.line_cnt = '0;
                            st_nxt.acc = '0;
                            if (corr_sum < 0) begin
                                st_nxt.corr = CORR_RST;
                            end else if (corr_sum > ACC_W'(CORR_MAX)) begin
                                st_nxt.corr = CORR_MAX;
                            end else begin
                                st_nxt.corr = corr_sum[CORR_W-1:0];
                            end
                        end else begin
                            st_nxt.line_cnt = st_r.line_cnt + 8'h01;
                        end
                    end
                end
                default: begin
                    st_nxt.clamp_st = CL_IDLE;
                end
            endcase
            if (black_clamp_pulse && sample) begin
                // Error is target minus result; positive raises the DAC
                st_nxt.err = $signed({5'h00, st_r.regs.level})
                    - $signed({1'b0, adc_data});
                st_nxt.acc = st_nxt.acc + ACC_W'(st_nxt.err);
            end
        end

        if (fifo_pop) begin
            st_nxt.dvalid = 1'b1;
            st_nxt.dout = st_r.regs.ctrl[CTRL_GRAY_BIT] ? bin2gray(fifo_dout)
                : fifo_dout;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{regs: '{opmode: OPMODE_RST, ctrl: CTRL_RST,
                level: LEVEL_RST, phase: PHASE_RST, update: UPDATE_RST},
                phase_cnt: '0, clamp_st: CL_IDLE, acc: '0, err: '0,
                line_cnt: '0, corr: CORR_RST, dout: '0, dvalid: 1'b0,
                rdata: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign dac_code = st_r.corr;
    assign data_out = st_r.dout;
    assign data_valid = st_r.dvalid;
    // Enables come straight from the control register so three-state is immediate
    assign data_oe = {ADC_W{!st_r.regs.ctrl[CTRL_TRISTATE_BIT]}};

    AST_CLAMP_ERR: assert property (@(posedge clk) disable iff (!rst_b)
        (black_clamp_pulse && sample && !loop_off) |=>
        (st_r.err == $signed({5'h00, $past(st_r.regs.level)})
            - $signed({1'b0, $past(adc_data)})))
        else $error("clamp error not formed from target and result");

    AST_LEVEL_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        (bus_req.wr && bus_req.addr == ADDR_LEVEL) |=>
        (st_r.regs.level == $past(bus_req.wdata[LEVEL_W-1:0])))
        else $error("clamp level write lost");

    AST_CORR_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (!loop_off && !upd_evt && !$past(loop_off)) |=> $stable(st_r.corr))
        else $error("correction moved outside an update");

    AST_SLOW_UPDATE: assert property (@(posedge clk) disable iff (!rst_b)
        upd_evt |-> (st_r.line_cnt + 8'h01
            >= lines_per_update(st_r.regs.update)) ##1 (st_r.line_cnt == 8'h00))
        else $error("update outside its line interval");

    AST_LOOP_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        loop_off |=> (st_r.acc == '0 && st_r.clamp_st == CL_IDLE))
        else $error("clamp loop active while disabled");

    AST_FIXED_OFFSET: assert property (@(posedge clk) disable iff (!rst_b)
        (loop_off && $stable(st_r.regs.level)) |=>
        (dac_code == CORR_W'($past(st_r.regs.level))))
        else $error("fixed offset not applied");

    AST_LATCH_PHASE: assert property (@(posedge clk) disable iff (!rst_b)
        (data_valid && !$past(transparent)) |->
        ($past(st_r.phase_cnt) == $past(st_r.regs.phase)))
        else $error("output latched off its phase");

    AST_TRANSPARENT: assert property (@(posedge clk) disable iff (!rst_b)
        (transparent && fifo_valid) |=> data_valid)
        else $error("transparent latch held data");

    AST_TRISTATE: assert property (@(posedge clk) disable iff (!rst_b)
        st_r.regs.ctrl[CTRL_TRISTATE_BIT] |-> (data_oe == '0))
        else $error("outputs driven while three-stated");

    AST_CODING: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_pop |=> (data_out == ($past(st_r.regs.ctrl[CTRL_GRAY_BIT])
            ? ($past(fifo_dout) ^ ($past(fifo_dout) >> 1)) : $past(fifo_dout))))
        else $error("output coding wrong");
endmodule : black_clamp_and_output_format

// *** inc/clamp_fmt_pkg.sv ***
// Constants, register map and carriers for the black clamp and output stage
package clamp_fmt_pkg;
    localparam int ADC_W = 12;
    localparam int LEVEL_W = 8;
    localparam int CORR_W = 10;
    localparam int ACC_W = 22;
    localparam int ADDR_W = 4;
    localparam int BUS_W = 16;
    localparam int PHASE_W = 2;
    localparam int FILT_SHIFT = 4;

    localparam logic [ADDR_W-1:0] ADDR_OPMODE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_LEVEL = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PHASE = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_UPDATE = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_CORR = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h6;

    localparam int OPMODE_CLAMP_OFF_BIT = 2;
    localparam int CTRL_TRISTATE_BIT = 3;
    localparam int CTRL_TRANSP_BIT = 4;
    localparam int CTRL_GRAY_BIT = 5;

    localparam logic [7:0] OPMODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'h00;
    localparam logic [PHASE_W-1:0] PHASE_RST = 2'h0;
    localparam logic [7:0] UPDATE_RST = 8'h01;
    localparam logic [CORR_W-1:0] CORR_RST = 10'h000;
    localparam logic [CORR_W-1:0] CORR_MAX = 10'h3FF;

    typedef enum logic [0:0] {
        CL_IDLE = 1'b0,
        CL_ACCUM = 1'b1
    } clamp_st_e;

    typedef struct packed {
        logic [7:0] opmode;
        logic [7:0] ctrl;
        logic [LEVEL_W-1:0] level;
        logic [PHASE_W-1:0] phase;
        logic [7:0] update;
    } regs_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BUS_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
endpackage : clamp_fmt_pkg

// *** testbench/black_clamp_and_output_format_test.sv ***
// Self-checking bench for the black clamp and output format block
`timescale 1ns/1ps

module black_clamp_and_output_format_test;
    import clamp_fmt_pkg::*;
    localparam int PIX_DIV = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    bus_req_s bus_req = '0;
    logic [BUS_W-1:0] rdata;
    logic [ADC_W-1:0] adc_data = '0;
    logic adc_valid = 1'b0;
    logic adc_ready;
    logic black_clamp_pulse = 1'b0;
    logic pixel_blank_pulse = 1'b0;
    logic [CORR_W-1:0] dac_code;
    logic [ADC_W-1:0] data_out;
    logic [ADC_W-1:0] data_oe;
    logic data_valid;
    logic prev_cp = 1'b0;
    logic full_seen = 1'b0;
    logic [31:0] lfsr_r = 32'h1F5E;
    logic [ADC_W-1:0] exp_q[$];
    int failures = 0;
    int n_checks = 0;
    int ctrl_m = 0, opm_m = 0, lvl_m = 0, upd_m = 1;
    int acc = 0, corr = 0, lines = 0;
    int cfg[4] = '{16'h0010, 16'h0030, 16'h0000, 16'h0020};

    always #2 clk = ~clk;

    black_clamp_and_output_format #(.PIX_DIV(PIX_DIV), .FIFO_DEPTH(8)) u_dut (
        .clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
        .adc_data(adc_data), .adc_valid(adc_valid), .adc_ready(adc_ready),
        .black_clamp_pulse(black_clamp_pulse),
        .pixel_blank_pulse(pixel_blank_pulse), .dac_code(dac_code),
        .data_out(data_out), .data_oe(data_oe), .data_valid(data_valid)
    );

    pixel_sink u_sink (
        .clk(clk), .rst_b(rst_b), .data_out(data_out), .data_oe(data_oe),
        .data_valid(data_valid)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Reference model, sampled mid-cycle so the inputs and ready are settled
    always @(negedge clk) begin
        if (rst_b && adc_valid && adc_ready === 1'b1) begin
            exp_q.push_back(ctrl_m[5] ? adc_data ^ (adc_data >> 1) : adc_data);
            if (black_clamp_pulse && !opm_m[2])
                acc += lvl_m - int'(adc_data);
        end
        if (rst_b && adc_valid && adc_ready === 1'b0)
            full_seen = 1'b1;
        if (opm_m[2]) begin
            acc = 0;
            lines = 0;
        end else if (prev_cp && !black_clamp_pulse) begin
            lines++;
            if (lines >= (upd_m == 0 ? 1 : upd_m)) begin
                corr += acc >>> 4;
                corr = corr < 0 ? 0 : (corr > 1023 ? 1023 : corr);
                acc = 0;
                lines = 0;
            end
        end
        prev_cp = black_clamp_pulse;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [ADDR_W-1:0] a, input int d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.wdata <= 16'(d);
        bus_req.wr <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
        case (a)
            ADDR_OPMODE: opm_m = d;
            ADDR_CTRL: ctrl_m = d;
            ADDR_LEVEL: lvl_m = d;
            ADDR_UPDATE: upd_m = d;
            default: ;
        endcase
    endtask : wr

    task automatic chkrd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask : chkrd

    // A refused word is held until the FIFO has room again
    task automatic pix(input logic [11:0] d, input logic cp, input logic bp);
        @(posedge clk);
        adc_data <= d;
        adc_valid <= 1'b1;
        black_clamp_pulse <= cp;
        pixel_blank_pulse <= bp;
        @(negedge clk);
        while (adc_ready !== 1'b1)
            @(negedge clk);
    endtask : pix

    task automatic idle;
        @(posedge clk);
        adc_valid <= 1'b0;
        black_clamp_pulse <= 1'b0;
        pixel_blank_pulse <= 1'b0;
    endtask : idle

    // Kind 0 blanking line, 1 black line, 2 effective line with 48 trailing
    task automatic line(input int kind);
        for (int j = 0; j < 64; j++) begin
            lfsr_r = lfsr(lfsr_r);
            pix(12'h040 + 12'(lfsr_r[4:0]), kind == 1 || (kind == 2 && j >= 16),
                kind == 0);
        end
        idle();
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(16'(dac_code), 16'(opm_m[2] ? lvl_m : corr));
    endtask : line

    task automatic drain;
        int k;
        k = 0;
        while (u_sink.got.size() < exp_q.size() && k < 4000) begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        chk(16'(u_sink.got.size()), 16'(exp_q.size()));
        while (exp_q.size() > 0 && u_sink.got.size() > 0)
            chk(u_sink.got.pop_front(), exp_q.pop_front());
        exp_q.delete();
        u_sink.got.delete();
    endtask : drain

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(16'(dac_code), 16'h0000);
        chk(16'(data_oe), 16'h0FFF);
        chkrd(ADDR_OPMODE, 16'h0000);
        chkrd(ADDR_CTRL, 16'h0000);
        chkrd(ADDR_LEVEL, 16'h0000);
        chkrd(ADDR_PHASE, 16'h0000);
        chkrd(ADDR_UPDATE, 16'h0001);
        chkrd(4'hF, 16'h0000);
        @(posedge clk);
        pixel_blank_pulse <= 1'b1;
        chkrd(ADDR_STATUS, 16'h0004);
        idle();
        wr(ADDR_LEVEL, 16'h00FF);
        chkrd(ADDR_LEVEL, 16'h00FF);
        wr(ADDR_CORR, 16'h0123);
        chkrd(ADDR_CORR, 16'h0000);
        wr(ADDR_CTRL, 16'h0008);
        @(negedge clk);
        chk(16'(data_oe), 16'h0000);
        wr(ADDR_CTRL, 16'h0000);
        @(negedge clk);
        chk(16'(data_oe), 16'h0FFF);
        // Transparent and latched, binary and Gray; latched runs only at latch phases 2 and 3
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL, cfg[i]);
            wr(ADDR_PHASE, i);
            repeat (16) begin
                lfsr_r = lfsr(lfsr_r);
                pix(lfsr_r[11:0], 1'b0, 1'b0);
            end
            idle();
            drain();
            chk(16'(u_sink.gap), cfg[i][4] ? 16'h0001 : 16'(PIX_DIV));
        end
        chk(full_seen, 1'b1);
        // Clamp loop: transparent keeps the FIFO from throttling the line
        wr(ADDR_CTRL, 16'h0010);
        wr(ADDR_LEVEL, 16'h0050);
        line(0);
        line(1);
        line(1);
        line(2);
        chkrd(ADDR_CORR, 16'(corr));
        wr(ADDR_UPDATE, 16'h0002);
        for (int i = 0; i < 3; i++)
            line(2);
        wr(ADDR_UPDATE, 16'h0000);
        line(2);
        wr(ADDR_LEVEL, 16'h00FF);
        line(1);
        line(1);
        wr(ADDR_LEVEL, 16'h0000);
        for (int i = 0; i < 4; i++)
            line(1);
        chkrd(ADDR_CORR, 16'(corr));
        wr(ADDR_OPMODE, 16'h0004);
        wr(ADDR_LEVEL, 16'h003C);
        line(1);
        line(2);
        drain();
        report_and_stop();
    end
endmodule : black_clamp_and_output_format_test

// *** testbench/pixel_sink.sv ***
// Downstream processing ASIC model: collects output words and their spacing
`timescale 1ns/1ps

module pixel_sink (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [clamp_fmt_pkg::ADC_W-1:0] data_out,
    input wire logic [clamp_fmt_pkg::ADC_W-1:0] data_oe,
    input wire logic data_valid
);
    import clamp_fmt_pkg::*;
    logic [ADC_W-1:0] got[$];
    int gap = 0;
    int since = 0;
    // A word is only seen while every pin is driven; a floating bus is lost
    // Sampled mid-cycle so the registered outputs have settled
    always @(negedge clk or negedge rst_b) begin
        if (!rst_b) begin
            since = 0;
        end else begin
            since = since + 1;
            if (data_valid === 1'b1 && data_oe === '1) begin
                got.push_back(data_out);
                gap = since;
                since = 0;
            end
        end
    end
endmodule : pixel_sink
